// File: uart_fifo_test_access_status_tb.sv
// Self-checking bench for the FIFO test access and queue status block
`timescale 1ns/1ns
`include "uft_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module uart_fifo_test_access_status_tb import uft_pkg::*;;
   logic         sys_clk = 1'h0;
   logic         rst     = 1'h1;
   logic         hsel    = 1'h1;
   logic [31:0]  haddr   = 32'h0;
   logic [1:0]   htrans  = 2'h0;
   logic         hwrite  = 1'h0;
   logic [2:0]   hsize   = 3'h2;
   logic [31:0]  hwdata  = 32'h0;
   logic         stall   = 1'h1;
   logic         hreadyout, hresp, rx_push, tx_pop, shifter_active, tx_valid, irq;
   logic [31:0]  hrdata;
   uft_byte_type rx_data, tx_data, got;
   logic [7:0]   n_got;
   int           n_errors = 0;
   int           n_tests  = 0;
   uft_top DUT
   (
      .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_push(rx_push),
      .rx_data(rx_data), .tx_pop(tx_pop), .shifter_active(shifter_active),
      .tx_data(tx_data), .tx_valid(tx_valid), .irq(irq)
   );
   uft_serial_partner P
   (
      .sys_clk(sys_clk), .stall(stall), .tx_valid(tx_valid), .tx_data(tx_data),
      .rx_push(rx_push), .rx_data(rx_data), .tx_pop(tx_pop),
      .shifter_active(shifter_active), .got(got), .n_got(n_got)
   );
   always #10 sys_clk = ~sys_clk;
   task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge sys_clk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      if (w)
         hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'h1);
      q = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] q;
      xfer(1'h1, a, d, q);
   endtask
   task automatic rc(input logic [31:0] a, e);
      logic [31:0] q;
      xfer(1'h0, a, 32'h0, q);
      `CHK(q, e)
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      #400000;
      n_errors++;
      print_verdict();
   end
   initial
   begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'h0;
      @(posedge sys_clk);
      wr(32'h5000_1014, 32'hff);
      rc(32'h5000_1014, 32'h0);
      rc(`UFT_ADDR_FAR, 32'h0);
      rc(`UFT_ADDR_USR, 32'h6);
      rc(`UFT_ADDR_TFL, 32'h0);
      rc(`UFT_ADDR_RFL, 32'h0);
      $display("reset test done");
      wr(`UFT_ADDR_DATA, 32'ha5);
      rc(`UFT_ADDR_TFL, 32'h1);
      rc(`UFT_ADDR_USR, 32'h1);
      wr(`UFT_ADDR_FAR, 32'h1);
      rc(`UFT_ADDR_FAR, 32'h1);
      rc(`UFT_ADDR_TFL, 32'h0);
      wr(`UFT_ADDR_DATA, 32'h3c);
      rc(`UFT_ADDR_RFL, 32'h1);
      rc(`UFT_ADDR_USR, 32'h1f);
      wr(`UFT_ADDR_FAR, 32'h0);
      rc(`UFT_ADDR_RFL, 32'h0);
      rc(`UFT_ADDR_USR, 32'h6);
      $display("holding test done");
      wr(`UFT_ADDR_QCTRL, 32'h1);
      wr(`UFT_ADDR_FAR, 32'h1);
      wr(`UFT_ADDR_DATA, 32'h0);
      rc(`UFT_ADDR_USR, 32'hf);
      rc(`UFT_ADDR_DATA, 32'h0);
      for (int i = 1; i < 16; i++)
         wr(`UFT_ADDR_DATA, 32'(i));
      rc(`UFT_ADDR_RFL, 32'h10);
      rc(`UFT_ADDR_USR, 32'h1f);
      wr(`UFT_ADDR_FAR, 32'h0);
      rc(`UFT_ADDR_RFL, 32'h0);
      $display("test access queue test done");
      for (int i = 0; i < 16; i++)
         wr(`UFT_ADDR_DATA, 32'h80 + 32'(i));
      rc(`UFT_ADDR_TFL, 32'h10);
      rc(`UFT_ADDR_USR, 32'h1);
      stall <= 1'h0;
      for (int k = 0; k < 400 && n_got !== 8'h10; k++)
         @(posedge sys_clk);
      `CHK(n_got, 8'h10)
      `CHK(got, 8'h8f)
      rc(`UFT_ADDR_TFL, 32'h0);
      rc(`UFT_ADDR_USR, 32'h6);
      $display("transmit drain test done");
      wr(`UFT_ADDR_IMASK, 32'h1);
      P.send(8'h5a);
      @(posedge sys_clk);
      `CHK(irq, 1'h1)
      rc(`UFT_ADDR_USR, 32'hf);
      rc(`UFT_ADDR_DATA, 32'h5a);
      rc(`UFT_ADDR_RFL, 32'h0);
      wr(`UFT_ADDR_ISTAT, 32'h1);
      @(posedge sys_clk);
      `CHK(irq, 1'h0)
      wr(`UFT_ADDR_IMASK, 32'h0);
      P.send(8'h11);
      rc(`UFT_ADDR_ISTAT, 32'h1);
      `CHK(irq, 1'h0)
      wr(`UFT_ADDR_ISTAT, 32'h1);
      rc(`UFT_ADDR_ISTAT, 32'h0);
      $display("interrupt test done");
      print_verdict();
   end
endmodule // uart_fifo_test_access_status_tb

// File: uft_defines.svh
// Address map, field positions, reset values and sizes of the FIFO test access block
`ifndef UFT_DEFINES_SVH
`define UFT_DEFINES_SVH
`define UFT_ADDR_DATA    32'h5000_1000
`define UFT_ADDR_QCTRL   32'h5000_1008
`define UFT_ADDR_FAR     32'h5000_1070
`define UFT_ADDR_USR     32'h5000_107c
`define UFT_ADDR_TFL     32'h5000_1080
`define UFT_ADDR_RFL     32'h5000_1084
`define UFT_ADDR_ISTAT   32'h5000_10a0
`define UFT_ADDR_IMASK   32'h5000_10a4
`define UFT_DEPTH        16
`define UFT_PTR_W        4
`define UFT_CNT_W        5
`define UFT_DATA_W       8
`define UFT_NCH          2
`define UFT_CH_RX        0
`define UFT_CH_TX        1
`define UFT_CAP_FIFO     5'h10
`define UFT_CAP_HOLD     5'h01
`define UFT_CNT_ZERO     5'h00
`define UFT_PTR_ZERO     4'h0
`define UFT_FAR_EN       0
`define UFT_QC_EN        0
`define UFT_QC_RXRST     1
`define UFT_QC_TXRST     2
`define UFT_USR_BUSY     0
`define UFT_USR_TFNF     1
`define UFT_USR_TFE      2
`define UFT_USR_RFNE     3
`define UFT_USR_RFF      4
`define UFT_USR_W        5
`define UFT_IRQ_RXDATA   0
`define UFT_IRQ_RXOVR    1
`define UFT_IRQ_TXLOST   2
`define UFT_IRQ_W        3
`define UFT_RST_FAR      1'b0
`define UFT_RST_QC       1'b0
`define UFT_RST_IRQ      3'h0
`define UFT_RST_BUSY     1'b0
`define UFT_HTRANS_ACT   1
`define UFT_HSIZE_WORD   3'h2
`define UFT_ZERO32       32'h0000_0000
`define UFT_ZERO8        8'h00
`endif

// File: uft_mem.sv
// Queue storage with registered read data
`timescale 1ns/1ns
module uft_mem
   import uft_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic         wr_en,
   input  wire uft_ptr_type  waddr,
   input  wire uft_byte_type wdata,
   input  wire uft_ptr_type  raddr,
   output uft_byte_type      rdata_r
);
   uft_byte_type mem [`UFT_DEPTH];

   // Storage has no reset; only the read register is cleared
   always_ff @(posedge sys_clk)
   begin
      if (wr_en)
         mem[waddr] <= wdata;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         rdata_r <= `UFT_ZERO8;
      else
         rdata_r <= mem[raddr];
   end
endmodule // uft_mem

// File: uft_pkg.sv
// Shared types of the FIFO test access block
`include "uft_defines.svh"
package uft_pkg;
   typedef logic [`UFT_DATA_W-1:0] uft_byte_type;
   typedef logic [`UFT_PTR_W-1:0]  uft_ptr_type;
   typedef logic [`UFT_CNT_W-1:0]  uft_cnt_type;
   typedef enum logic {uft_bus_idle, uft_bus_rdwait} uft_bus_state_type;
endpackage

// File: uft_serial_partner.sv
// Serial shifter model: takes transmit bytes and delivers received bytes
`timescale 1ns/1ns
module uft_serial_partner
   import uft_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         stall,
   input  wire logic         tx_valid,
   input  wire uft_byte_type tx_data,
   output logic              rx_push,
   output uft_byte_type      rx_data,
   output logic              tx_pop,
   output logic              shifter_active,
   output uft_byte_type      got,
   output logic [7:0]        n_got
);
   initial {rx_push, rx_data, tx_pop, shifter_active, got, n_got} = '0;
   // Pop one edge after valid is seen while stall is low, never twice in a row
   always @(posedge sys_clk)
   begin
      tx_pop <= tx_valid && !tx_pop && !stall;
      shifter_active <= tx_pop;
      if (tx_pop && tx_valid)
      begin
         got <= tx_data;
         n_got <= n_got + 8'h01;
      end
   end
   task automatic send(input uft_byte_type b);
      rx_push <= 1'h1;
      rx_data <= b;
      @(posedge sys_clk);
      rx_push <= 1'h0;
      // Stale byte must not look valid after the strobe
      rx_data <= ~b;
   endtask
endmodule // uft_serial_partner

// File: uft_top.sv
// FIFO test access, queue status and level reporting over AHB-Lite
// Function
// R1: Test access bit zero enables mode, resets zero
// R2: Without option, test access writes ignored
// R3: Test mode with queues: write rx, read tx
// R4: Test mode without queues: holding registers accessed
// R5: Test mode change clears both queues
// R6: Status bit four shows receive queue full
// R7: Status bit three shows receive queue nonempty
// R8: Status bit two shows transmit queue empty
// R9: Status bit one shows transmit not full
// R10: Status bit zero shows serial activity
// R11: Activity may miss an arriving start bit
// R12: Separate serial clock delays activity flag
// R13: Two level registers report queue occupancy
// R14: Queue enable selects receive head or holding
// R15: Levels and flags update with occupancy change
`timescale 1ns/1ns
module uft_top
   import uft_pkg::*;
#(
   parameter bit FIFO_ACCESS = 1'b1
)
(
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic              hreadyout,
   output logic [31:0]       hrdata,
   output logic              hresp,
   input  wire logic         rx_push,
   input  wire uft_byte_type rx_data,
   input  wire logic         tx_pop,
   input  wire logic         shifter_active,
   output uft_byte_type      tx_data,
   output logic              tx_valid,
   output logic              irq
);

   function automatic logic hit(input logic [31:0] a, input logic [31:0] reg_addr);
      return a == reg_addr;
   endfunction

   // Bus slave state
   uft_bus_state_type st_r;
   uft_bus_state_type st_nxt;
   logic [31:0]       addr_r;
   logic              wr_pend_r;
   logic              hready_r;
   logic [31:0]       hrdata_r;
   logic              hresp_r;

   // Control and status
   logic                  fifo_test_access_enable;
   logic                  fifo_en_r;
   logic [`UFT_IRQ_W-1:0] ist_r;
   logic [`UFT_IRQ_W-1:0] ist_nxt;
   logic [`UFT_IRQ_W-1:0] imask_r;
   logic [`UFT_IRQ_W-1:0] imask_nxt;
   logic [`UFT_IRQ_W-1:0] ev;
   logic                  irq_r;
   logic                  busy_r;
   logic                  tx_valid_r;

   // Queue channels, index 0 receive and 1 transmit
   uft_ptr_type  wp_r   [`UFT_NCH];
   uft_ptr_type  rp_r   [`UFT_NCH];
   uft_cnt_type  cnt_r  [`UFT_NCH];
   logic         vld_r  [`UFT_NCH];
   uft_byte_type rdata  [`UFT_NCH];
   uft_byte_type win    [`UFT_NCH];
   logic         push_req [`UFT_NCH];
   logic         pop    [`UFT_NCH];
   logic         clr    [`UFT_NCH];
   logic         full   [`UFT_NCH];
   logic         empty  [`UFT_NCH];
   logic         acc    [`UFT_NCH];
   logic         ovw    [`UFT_NCH];
   logic         lost   [`UFT_NCH];

   // Address phase and data phase decode
   wire take     = hsel && htrans[`UFT_HTRANS_ACT] && hready && (hsize == `UFT_HSIZE_WORD);
   wire rd_now   = (st_r == uft_bus_rdwait);
   wire wr_data  = wr_pend_r && hit(addr_r, `UFT_ADDR_DATA);
   wire wr_far   = wr_pend_r && hit(addr_r, `UFT_ADDR_FAR) && FIFO_ACCESS; // R2
   wire wr_qc    = wr_pend_r && hit(addr_r, `UFT_ADDR_QCTRL);
   wire wr_ist   = wr_pend_r && hit(addr_r, `UFT_ADDR_ISTAT);
   wire wr_imask = wr_pend_r && hit(addr_r, `UFT_ADDR_IMASK);
   wire rd_data  = rd_now && hit(addr_r, `UFT_ADDR_DATA);

   wire far_chg  = wr_far && (hwdata[`UFT_FAR_EN] != fifo_test_access_enable); // R5
   wire qen_chg  = wr_qc && (hwdata[`UFT_QC_EN] != fifo_en_r);
   // Holding register mode behaves as a queue of one entry
   wire uft_cnt_type cap = fifo_en_r ? `UFT_CAP_FIFO : `UFT_CAP_HOLD; // R14

   wire test_fifo = fifo_test_access_enable && fifo_en_r;
   wire test_hold = fifo_test_access_enable && !fifo_en_r;

   // Queue clear on mode change or explicit reset bit
   assign clr[`UFT_CH_RX] = far_chg || qen_chg || (wr_qc && hwdata[`UFT_QC_RXRST]); // R5
   assign clr[`UFT_CH_TX] = far_chg || qen_chg || (wr_qc && hwdata[`UFT_QC_TXRST]); // R5

   // In test mode the serial side is cut off so the bus owns both queues
   assign push_req[`UFT_CH_RX] = fifo_test_access_enable ? wr_data : rx_push; // R3 R4
   assign push_req[`UFT_CH_TX] = !fifo_test_access_enable && wr_data;
   assign win[`UFT_CH_RX]      = fifo_test_access_enable ? hwdata[`UFT_DATA_W-1:0] : rx_data;
   assign win[`UFT_CH_TX]      = hwdata[`UFT_DATA_W-1:0];
   assign pop[`UFT_CH_RX]      = !fifo_test_access_enable && rd_data && vld_r[`UFT_CH_RX]; // R14
   assign pop[`UFT_CH_TX]      = fifo_test_access_enable
                                 ? (rd_data && test_fifo && vld_r[`UFT_CH_TX]) // R3
                                 : (tx_pop && vld_r[`UFT_CH_TX]);

   genvar i;
   generate
      for (i = 0; i < `UFT_NCH; i++)
      begin : g_ch
         wire         we    = (acc[i] || ovw[i]) && !clr[i];
         wire uft_ptr_type waddr = ovw[i] ? rp_r[i] : wp_r[i];
         wire uft_cnt_type cnt_nxt = clr[i] ? `UFT_CNT_ZERO
                                     : uft_cnt_type'(cnt_r[i] + uft_cnt_type'(acc[i])
                                                     - uft_cnt_type'(pop[i])); // R15
         wire uft_ptr_type wp_nxt = clr[i] ? `UFT_PTR_ZERO
                                    : uft_ptr_type'(wp_r[i] + uft_ptr_type'(acc[i]));
         wire uft_ptr_type rp_nxt = clr[i] ? `UFT_PTR_ZERO
                                    : uft_ptr_type'(rp_r[i] + uft_ptr_type'(pop[i]));
         wire         chg   = acc[i] || pop[i] || ovw[i] || clr[i];

         assign full[i]  = (cnt_r[i] == cap); // R15
         assign empty[i] = (cnt_r[i] == `UFT_CNT_ZERO); // R15
         assign acc[i]   = push_req[i] && (!full[i] || pop[i]);
         // Full holding register is overwritten; a full queue drops the word
         assign ovw[i]   = push_req[i] && full[i] && !pop[i] && !fifo_en_r;
         assign lost[i]  = push_req[i] && full[i] && !pop[i] && fifo_en_r;

         always_ff @(posedge sys_clk or posedge rst)
         begin
            if (rst)
            begin
               wp_r[i]  <= `UFT_PTR_ZERO;
               rp_r[i]  <= `UFT_PTR_ZERO;
               cnt_r[i] <= `UFT_CNT_ZERO; // R13
            end
            else
            begin
               wp_r[i]  <= wp_nxt;
               rp_r[i]  <= rp_nxt;
               cnt_r[i] <= cnt_nxt; // R15
            end
         end

         // Head is trusted only after read data has settled one cycle
         always_ff @(posedge sys_clk or posedge rst)
         begin
            if (rst)
               vld_r[i] <= 1'b0;
            else
               vld_r[i] <= !empty[i] && !chg;
         end

         uft_mem u_mem
         (
            .sys_clk (sys_clk),
            .rst     (rst),
            .wr_en   (we),
            .waddr   (waddr),
            .wdata   (win[i]),
            .raddr   (rp_r[i]),
            .rdata_r (rdata[i])
         );
      end
   endgenerate

   // Status word and read selection
   wire [`UFT_USR_W-1:0] usr_val =
      {full[`UFT_CH_RX],    // R6
       !empty[`UFT_CH_RX],  // R7
       empty[`UFT_CH_TX],   // R8
       !full[`UFT_CH_TX],   // R9
       busy_r};             // R10

   wire rd_src_tx = fifo_test_access_enable;
   wire uft_byte_type data_val = rd_src_tx
      ? (vld_r[`UFT_CH_TX] ? rdata[`UFT_CH_TX] : `UFT_ZERO8) // R3 R4
      : (vld_r[`UFT_CH_RX] ? rdata[`UFT_CH_RX] : `UFT_ZERO8); // R14

   wire [31:0] rd_val =
      hit(addr_r, `UFT_ADDR_DATA)  ? 32'(data_val) :
      hit(addr_r, `UFT_ADDR_QCTRL) ? 32'(fifo_en_r) :
      hit(addr_r, `UFT_ADDR_FAR)   ? 32'(fifo_test_access_enable) : // R2
      hit(addr_r, `UFT_ADDR_USR)   ? 32'(usr_val) :
      hit(addr_r, `UFT_ADDR_TFL)   ? 32'(cnt_r[`UFT_CH_TX]) : // R13
      hit(addr_r, `UFT_ADDR_RFL)   ? 32'(cnt_r[`UFT_CH_RX]) : // R13
      hit(addr_r, `UFT_ADDR_ISTAT) ? 32'(ist_r) :
      hit(addr_r, `UFT_ADDR_IMASK) ? 32'(imask_r) :
      `UFT_ZERO32;

   // Bus state machine: reads take one wait state so queue heads can settle
   always_comb
   begin
      st_nxt = st_r;
      unique case (st_r)
         uft_bus_idle:
            if (take && !hwrite)
               st_nxt = uft_bus_rdwait;
         uft_bus_rdwait:
            st_nxt = uft_bus_idle;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         st_r      <= uft_bus_idle;
         addr_r    <= `UFT_ZERO32;
         wr_pend_r <= 1'b0;
      end
      else
      begin
         st_r      <= st_nxt;
         addr_r    <= take ? haddr : addr_r;
         wr_pend_r <= take && hwrite;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         hready_r <= 1'b1;
         hrdata_r <= `UFT_ZERO32;
         hresp_r  <= 1'b0;
      end
      else
      begin
         hready_r <= !(take && !hwrite);
         hrdata_r <= rd_now ? rd_val : hrdata_r;
         hresp_r  <= 1'b0;
      end
   end

   // Control registers
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         fifo_test_access_enable <= `UFT_RST_FAR; // R1
         fifo_en_r               <= `UFT_RST_QC;
      end
      else
      begin
         if (wr_far)
            fifo_test_access_enable <= hwdata[`UFT_FAR_EN]; // R1 R2
         if (wr_qc)
            fifo_en_r <= hwdata[`UFT_QC_EN];
      end
   end

   // Sticky events: a new event wins over a same-cycle clear
   assign ev[`UFT_IRQ_RXDATA] = acc[`UFT_CH_RX] || ovw[`UFT_CH_RX];
   assign ev[`UFT_IRQ_RXOVR]  = lost[`UFT_CH_RX] || ovw[`UFT_CH_RX];
   assign ev[`UFT_IRQ_TXLOST] = lost[`UFT_CH_TX] || ovw[`UFT_CH_TX];
   assign ist_nxt   = (ist_r & ~(wr_ist ? hwdata[`UFT_IRQ_W-1:0] : `UFT_RST_IRQ)) | ev;
   assign imask_nxt = wr_imask ? hwdata[`UFT_IRQ_W-1:0] : imask_r;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         ist_r   <= `UFT_RST_IRQ;
         imask_r <= `UFT_RST_IRQ;
         irq_r   <= 1'b0;
      end
      else
      begin
         ist_r   <= ist_nxt;
         imask_r <= imask_nxt;
         irq_r   <= |(ist_nxt & imask_nxt);
      end
   end

   // Valid is registered so the output comes straight from a flip-flop
   wire far_nxt    = wr_far ? hwdata[`UFT_FAR_EN] : fifo_test_access_enable;
   wire tx_vld_nxt = !empty[`UFT_CH_TX] && !g_ch[`UFT_CH_TX].chg && !far_nxt;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         tx_valid_r <= 1'b0;
      else
         tx_valid_r <= tx_vld_nxt;
   end

   // Activity: shifter busy or any word buffered. A start bit still being
   // qualified by the shifter is not yet seen here. With a single clock there
   // is no extra synchroniser lag on this flag.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         busy_r <= `UFT_RST_BUSY; // R10
      else
         busy_r <= shifter_active // R11 R12
                   || !empty[`UFT_CH_RX] || !empty[`UFT_CH_TX]; // R10
   end

   assign hreadyout = hready_r;
   assign hrdata    = hrdata_r;
   assign hresp     = hresp_r;
   assign tx_data   = rdata[`UFT_CH_TX];
   // Shifter sees nothing while the bus owns the transmit queue
   assign tx_valid  = tx_valid_r;
   assign irq       = irq_r;

   wire unused_ok = test_hold;
endmodule // uft_top

// File: uft_top_checker.sv
// Concurrent checks on the bus and serial ports of the FIFO test access block
`timescale 1ns/1ns
`include "uft_defines.svh"
module uft_top_checker
   import uft_pkg::*;
#(
   parameter bit FIFO_ACCESS = 1'b1
)
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        hresp,
   input wire logic        tx_pop,
   input wire logic        tx_valid
);
   wire  take = hsel && htrans[1] && hready && hsize == `UFT_HSIZE_WORD;
   wire  rd_take = take && !hwrite;
   logic wf_r;
   logic far_r;
   // Shadow of the mode bit, so only real mode changes are judged
   wire  chg = wf_r && FIFO_ACCESS && hwdata[`UFT_FAR_EN] != far_r;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         wf_r  <= 1'h0;
         far_r <= 1'h0;
      end
      else
      begin
         wf_r <= take && hwrite && haddr == `UFT_ADDR_FAR;
         if (wf_r && FIFO_ACCESS)
            far_r <= hwdata[`UFT_FAR_EN];
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_okay; hresp == 1'h0; endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   property p_wr_ready; take && hwrite |=> hreadyout; endproperty
   a_wr_ready: assert property (p_wr_ready) else $error("write stalled");
   property p_rd_wait; rd_take |=> !hreadyout ##1 hreadyout; endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
   property p_ready_cause; !hreadyout |-> $past(rd_take); endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("stray wait");
   property p_hold; $past(hreadyout) |-> $stable(hrdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_pop; tx_pop && tx_valid |=> !tx_valid; endproperty
   a_pop: assert property (p_pop) else $error("valid after pop");
   property p_tm_on; wf_r && FIFO_ACCESS && hwdata[0] |=> !tx_valid; endproperty
   a_tm_on: assert property (p_tm_on) else $error("serial side live in test");
   property p_tm_chg; chg |=> !tx_valid [*2]; endproperty
   a_tm_chg: assert property (p_tm_chg) else $error("queue kept on mode change");
endmodule // uft_top_checker
bind uft_top uft_top_checker #(.FIFO_ACCESS(FIFO_ACCESS)) u_chk
(
   .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tx_pop(tx_pop),
   .tx_valid(tx_valid)
);
